// >>> rtl/rmii_pins_pkg.sv
package rmii_pins_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         SYS_CLK_PERIOD_NS  = 40;
  localparam int         LINK_CLK_PERIOD_NS = 320;
  localparam int         REF_HALF_CYCLES    = LINK_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
  localparam logic [1:0] REF_DIV_LAST       = 2'(REF_HALF_CYCLES - 1);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_STRAP_STATUS = 5'h19;
  localparam logic [4:0] ADDR_INT_CTRL     = 5'h1B;
  localparam logic [4:0] ADDR_VENDOR_CTRL  = 5'h1F;

  localparam int VC_NAND_TREE_BIT = 0;
  localparam int VC_WAKE_OPT2_BIT = 1;
  localparam int VC_CLK50_BIT     = 7;
  localparam int VC_INT_HIGH_BIT  = 9;

  localparam int EV_LINK_UP   = 0;
  localparam int EV_LINK_DOWN = 1;
  localparam int EV_RX_ERROR  = 2;
  localparam int EV_WAKE      = 3;
  localparam int EV_COUNT     = 4;
  localparam int INT_MASK_LSB = 8;

  localparam int ST_ADDR_LSB = 0;
  localparam int ST_WAKE_BIT = 2;
  localparam int ST_DONE_BIT = 3;

  localparam logic [15:0]         VENDOR_CTRL_RESET = 16'h0000;
  localparam logic [EV_COUNT-1:0] INT_MASK_RESET    = 4'h0;
  localparam logic [EV_COUNT-1:0] INT_STATUS_RESET  = 4'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       crs_dv;
    logic       rx_er;
    logic [1:0] rxd;
  } rx_pins_t;

  typedef struct packed {
    logic       tx_en;
    logic [1:0] txd;
  } tx_pins_t;

  typedef enum logic [1:0] {ST_FILL1, ST_FILL2, ST_LATCH, ST_RUN} strap_state_t;

  function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] target);
    reg_hit = (addr == target);
  endfunction : reg_hit

endpackage : rmii_pins_pkg

// >>> rtl/rmii_phy_pin_interface.sv
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module rmii_phy_pin_interface
  import rmii_pins_pkg::*;
(
  // clock, reset, enable
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        CLK_EN_IN,
  // register port
  input  wire logic [4:0]  REG_ADDR_IN,
  input  wire logic [15:0] REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output logic      [15:0] REG_RDATA_OUT,
  // variant strap, reference clock input and reference clock output
  input  wire logic        CLOCK_INPUT_VARIANT_IN,
  input  wire logic        CRYSTAL_CLOCK_IN,
  output logic             REF_CLK_OUT,
  output logic             REF_CLK_OE_OUT,
  // receive pins toward the MAC
  input  wire rx_pins_t    RX_PINS_IN,
  output rx_pins_t         RX_PINS_OUT,
  output logic             RX_PINS_OE_OUT,
  // transmit pins from the MAC
  input  wire tx_pins_t    TX_PINS_IN,
  output logic             TXD1_OUT,
  output logic             TXD1_OE_OUT,
  // core side
  input  wire rx_pins_t    RX_CORE_IN,
  output logic      [1:0]  TX_DATA_OUT,
  output logic             TX_VALID_OUT,
  input  wire logic        LINK_UP_IN,
  input  wire logic        LINK_DOWN_IN,
  input  wire logic        WAKE_EVENT_IN,
  // interrupt
  output logic             IRQ_OUT,
  output logic             INT_PIN_OUT,
  output logic             INT_PIN_OE_OUT
);

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic       ref_s3;
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
    begin
      sync1  <= 7'h00;
      sync2  <= 7'h00;
      ref_s3 <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      sync1  <= {CRYSTAL_CLOCK_IN, CLOCK_INPUT_VARIANT_IN, TX_PINS_IN, RX_PINS_IN.crs_dv, RX_PINS_IN.rx_er};
      sync2  <= sync1;
      ref_s3 <= sync2[6];
    end

  logic     ext_ref;
  logic     variant_pin;
  tx_pins_t tx_pins;
  logic     crs_pin;
  logic     rxer_pin;
  assign {ext_ref, variant_pin, tx_pins, crs_pin, rxer_pin} = sync2;

  // ----------------------------------------------------------------
  // strap sequencer
  // ----------------------------------------------------------------
  strap_state_t strap_state;
  logic [1:0]   strap_mgmt_address_low;
  logic         wake_output_enable_strap;
  logic         running;
  assign running = (strap_state == ST_RUN);

  // sync chain refills after release, so the latch waits two edges
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
      strap_state <= ST_FILL1;
    else if (CLK_EN_IN)
      case (strap_state)
        ST_FILL1: strap_state <= ST_FILL2;
        ST_FILL2: strap_state <= ST_LATCH;
        ST_LATCH: strap_state <= ST_RUN;
        ST_RUN:   strap_state <= ST_RUN;
        default:  strap_state <= ST_FILL1;
      endcase

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
    begin
      strap_mgmt_address_low   <= 2'h0;
      wake_output_enable_strap <= 1'b0;
    end
    else if (CLK_EN_IN && strap_state == ST_LATCH)
    begin
      strap_mgmt_address_low   <= {2{crs_pin}};
      wake_output_enable_strap <= rxer_pin;
    end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0]         vendor_ctrl;
  logic [EV_COUNT-1:0] int_status;
  logic [EV_COUNT-1:0] int_mask;
  logic [EV_COUNT-1:0] events;
  logic                wr_int;
  logic                wr_vendor;
  assign wr_int    = REG_WR_IN && reg_hit(REG_ADDR_IN, ADDR_INT_CTRL);
  assign wr_vendor = REG_WR_IN && reg_hit(REG_ADDR_IN, ADDR_VENDOR_CTRL);

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
      vendor_ctrl <= VENDOR_CTRL_RESET;
    else if (CLK_EN_IN)
    begin
      if (wr_vendor)
        vendor_ctrl <= REG_WDATA_IN;
      else if (strap_state == ST_LATCH)
        vendor_ctrl[VC_CLK50_BIT] <= variant_pin;
    end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
      int_mask <= INT_MASK_RESET;
    else if (CLK_EN_IN && wr_int)
      int_mask <= REG_WDATA_IN[INT_MASK_LSB +: EV_COUNT];

  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
      int_status <= INT_STATUS_RESET;
    else if (CLK_EN_IN)
      int_status <= (int_status & ~(wr_int ? REG_WDATA_IN[EV_COUNT-1:0] : 4'h0)) | events;

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
      REG_RDATA_OUT <= 16'h0000;
    else if (CLK_EN_IN)
    begin
      if (!REG_RD_IN)
        REG_RDATA_OUT <= 16'h0000;
      else if (reg_hit(REG_ADDR_IN, ADDR_INT_CTRL))
        REG_RDATA_OUT <= {4'h0, int_mask, 4'h0, int_status};
      else if (reg_hit(REG_ADDR_IN, ADDR_VENDOR_CTRL))
        REG_RDATA_OUT <= vendor_ctrl;
      else if (reg_hit(REG_ADDR_IN, ADDR_STRAP_STATUS))
        REG_RDATA_OUT <= {12'h000, running, wake_output_enable_strap, strap_mgmt_address_low};
      else
        REG_RDATA_OUT <= 16'h0000;
    end

  logic mode_50;
  logic nand_mode;
  assign mode_50   = vendor_ctrl[VC_CLK50_BIT];
  assign nand_mode = vendor_ctrl[VC_NAND_TREE_BIT];

  // ----------------------------------------------------------------
  // reference clock
  // ----------------------------------------------------------------
  logic [1:0] ref_div;
  logic       ref_gen;
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
    begin
      ref_div <= 2'h0;
      ref_gen <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      ref_div <= (ref_div == REF_DIV_LAST) ? 2'h0 : ref_div + 2'h1;
      if (ref_div == REF_DIV_LAST)
        ref_gen <= ~ref_gen;
    end

  assign REF_CLK_OUT    = ref_gen;
  assign REF_CLK_OE_OUT = running && !mode_50;

  // in 50MHz mode the link runs on the externally supplied clock
  logic link_edge;
  assign link_edge = mode_50 ? (ext_ref && !ref_s3)
                             : (ref_div == REF_DIV_LAST && !ref_gen);

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
      RX_PINS_OUT <= '0;
    else if (CLK_EN_IN && link_edge)
    begin
      RX_PINS_OUT.crs_dv <= RX_CORE_IN.crs_dv;
      RX_PINS_OUT.rx_er  <= RX_CORE_IN.rx_er;
      RX_PINS_OUT.rxd    <= RX_CORE_IN.crs_dv ? RX_CORE_IN.rxd : 2'h0;
    end

  assign RX_PINS_OE_OUT = running;

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  logic nand_result;
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    if (RST_IN)
    begin
      TX_DATA_OUT  <= 2'h0;
      TX_VALID_OUT <= 1'b0;
      nand_result  <= 1'b1;
    end
    else if (CLK_EN_IN)
    begin
      TX_VALID_OUT <= link_edge && tx_pins.tx_en && running && !nand_mode;
      if (link_edge && tx_pins.tx_en && running && !nand_mode)
        TX_DATA_OUT <= tx_pins.txd;
      nand_result <= ~&{tx_pins.tx_en, tx_pins.txd[0], crs_pin, rxer_pin};
    end

  assign TXD1_OUT    = nand_result;
  assign TXD1_OE_OUT = running && nand_mode;

  // ----------------------------------------------------------------
  // interrupt and wake pin
  // ----------------------------------------------------------------
  assign events = {WAKE_EVENT_IN,
                   CLK_EN_IN && link_edge && RX_CORE_IN.rx_er,
                   LINK_DOWN_IN,
                   LINK_UP_IN};
  assign IRQ_OUT = |(int_status & int_mask);

  logic wake_opt2;
  assign wake_opt2 = vendor_ctrl[VC_WAKE_OPT2_BIT] && wake_output_enable_strap;

  // open drain: active high is shown by releasing to the pull-up
  assign INT_PIN_OUT    = 1'b0;
  assign INT_PIN_OE_OUT = !running ? 1'b0 :
                          wake_opt2 ? int_status[EV_WAKE] :
                          (vendor_ctrl[VC_INT_HIGH_BIT] ? !IRQ_OUT : IRQ_OUT);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  property p_strap_hold;
    running && $past(running) |-> $stable(strap_mgmt_address_low) && $stable(wake_output_enable_strap);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed while running");

  property p_strap_latch;
    CLK_EN_IN && strap_state == ST_LATCH |=> strap_mgmt_address_low == {2{$past(crs_pin)}};
  endproperty
  a_strap_latch: assert property (p_strap_latch) else $error("address strap wrong");

  property p_wake_latch;
    CLK_EN_IN && strap_state == ST_LATCH |=> wake_output_enable_strap == $past(rxer_pin);
  endproperty
  a_wake_latch: assert property (p_wake_latch) else $error("wake strap wrong");

  property p_ref_oe;
    REF_CLK_OE_OUT |-> running && !vendor_ctrl[VC_CLK50_BIT];
  endproperty
  a_ref_oe: assert property (p_ref_oe) else $error("ref clock driven in 50MHz mode");

  property p_ref_toggle;
    CLK_EN_IN && ref_div == REF_DIV_LAST |=> REF_CLK_OUT != $past(REF_CLK_OUT);
  endproperty
  a_ref_toggle: assert property (p_ref_toggle) else $error("ref clock not toggling");

  property p_mode_write;
    CLK_EN_IN && wr_vendor |=> mode_50 == $past(REG_WDATA_IN[VC_CLK50_BIT]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");

  property p_rx_follow;
    CLK_EN_IN && link_edge |=> RX_PINS_OUT.crs_dv == $past(RX_CORE_IN.crs_dv)
                               && RX_PINS_OUT.rx_er == $past(RX_CORE_IN.rx_er);
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("receive pins wrong");

  property p_rxd_idle;
    !RX_PINS_OUT.crs_dv |-> RX_PINS_OUT.rxd == 2'h0;
  endproperty
  a_rxd_idle: assert property (p_rxd_idle) else $error("receive data outside valid");

  property p_tx_capture;
    CLK_EN_IN && link_edge && tx_pins.tx_en && running && !nand_mode
      |=> TX_VALID_OUT && TX_DATA_OUT == $past(tx_pins.txd);
  endproperty
  a_tx_capture: assert property (p_tx_capture) else $error("transmit bits missed");

  property p_tx_quiet;
    TX_VALID_OUT |-> $past(tx_pins.tx_en) && $past(link_edge);
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("transmit without enable");

  property p_nand_oe;
    TXD1_OE_OUT |-> nand_mode && !TX_VALID_OUT;
  endproperty
  a_nand_oe: assert property (p_nand_oe) else $error("nand output while capturing");

  property p_irq_set;
    CLK_EN_IN && LINK_UP_IN && int_mask[EV_LINK_UP] |=> IRQ_OUT;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("event not raising interrupt");

  property p_int_low;
    running && !wake_opt2 && !vendor_ctrl[VC_INT_HIGH_BIT] |-> INT_PIN_OE_OUT == IRQ_OUT;
  endproperty
  a_int_low: assert property (p_int_low) else $error("active low interrupt wrong");

  property p_wake_pin;
    running && wake_opt2 |-> INT_PIN_OE_OUT == int_status[EV_WAKE];
  endproperty
  a_wake_pin: assert property (p_wake_pin) else $error("wake pin wrong");

  property p_open_drain;
    INT_PIN_OE_OUT |-> !INT_PIN_OUT;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("interrupt pin driven high");

  property p_variant;
    CLK_EN_IN && strap_state == ST_LATCH && !wr_vendor |=> mode_50 == $past(variant_pin);
  endproperty
  a_variant: assert property (p_variant) else $error("variant default wrong");

  c_tx_frame: cover property (TX_VALID_OUT ##[1:20] TX_VALID_OUT);
  c_mode50:   cover property (running && mode_50 && link_edge);
  c_irq:      cover property (IRQ_OUT ##[1:10] !IRQ_OUT);
  c_wake:     cover property (wake_opt2 && INT_PIN_OE_OUT);

endmodule : rmii_phy_pin_interface

// >>> bench/mac_model.sv
`timescale 1ns/1ps
module mac_model
  import rmii_pins_pkg::*;
(
  // clocks
  input  wire logic       clk_in,
  input  wire logic       ref_clk_in,
  // frame request
  input  wire logic [7:0] frame_len_in,
  input  wire logic       start_in,
  // transmit pins and send notes
  output tx_pins_t        tx_pins_out,
  output logic            note_out,
  output logic            busy_out
);
  logic       ref_prev;
  logic [7:0] left;
  integer     seed;

  initial
  begin
    seed        = 32'h7D1D0D8F;
    ref_prev    = 1'b0;
    left        = 8'h00;
    note_out    = 1'b0;
    tx_pins_out = 3'h0;
  end

  // data moves at mid-period so the resync inside the device keeps half a period of setup
  always @(posedge clk_in)
  begin
    ref_prev <= ref_clk_in;
    note_out <= 1'b0;
    if (start_in)
      left <= frame_len_in;
    else if (ref_prev && !ref_clk_in)
    begin
      if (left != 8'h00)
      begin
        tx_pins_out <= {1'b1, 2'($random(seed))};
        note_out    <= 1'b1;
        left        <= left - 8'h01;
      end
      else
        tx_pins_out <= {1'b0, ~tx_pins_out.txd};
    end
  end

  assign busy_out = (left != 8'h00);
endmodule : mac_model

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench
  import rmii_pins_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [4:0]  addr    = 5'h00;
  logic [15:0] wdata   = 16'h0000;
  logic        link_up = 1'b0;
  logic        link_dn = 1'b0;
  logic        wake    = 1'b0;
  logic        crystal = 1'b0;
  logic        use_xtl = 1'b0;
  logic        variant = 1'b0;
  logic        start   = 1'b0;
  logic [7:0]  flen    = 8'h00;
  rx_pins_t    strap   = 4'hC;
  rx_pins_t    core    = 4'h0;
  rx_pins_t    rx_out;
  tx_pins_t    tx_pins;
  logic [15:0] rdata;
  logic [1:0]  tx_data;
  logic        ref_clk, ref_oe, rx_oe, txd1, txd1_oe, tx_valid, irq, int_d, int_oe, note, busy;
  logic        int_wire;
  logic [1:0]  exp_q[$];
  integer      errors    = 0;
  integer      tests_run = 0;
  integer      seed      = 32'h7D1D0D8F;

  always #20 sys_clk = ~sys_clk;

  // free-running external reference, phase unrelated to the system clock
  initial
  begin
    #7;
    forever #160 crystal = ~crystal;
  end

  // open-drain pin with its weak pull-up
  assign int_wire = int_oe ? int_d : 1'b1;

  rmii_phy_pin_interface uut (
    .SYS_CLK_IN(sys_clk), .RST_IN(rst), .CLK_EN_IN(1'b1),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .CLOCK_INPUT_VARIANT_IN(variant), .CRYSTAL_CLOCK_IN(crystal), .REF_CLK_OUT(ref_clk), .REF_CLK_OE_OUT(ref_oe),
    .RX_PINS_IN(strap), .RX_PINS_OUT(rx_out), .RX_PINS_OE_OUT(rx_oe),
    .TX_PINS_IN(tx_pins), .TXD1_OUT(txd1), .TXD1_OE_OUT(txd1_oe),
    .RX_CORE_IN(core), .TX_DATA_OUT(tx_data), .TX_VALID_OUT(tx_valid),
    .LINK_UP_IN(link_up), .LINK_DOWN_IN(link_dn), .WAKE_EVENT_IN(wake),
    .IRQ_OUT(irq), .INT_PIN_OUT(int_d), .INT_PIN_OE_OUT(int_oe));

  mac_model mac (
    .clk_in(sys_clk), .ref_clk_in(use_xtl ? crystal : ref_clk), .frame_len_in(flen), .start_in(start),
    .tx_pins_out(tx_pins), .note_out(note), .busy_out(busy));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task check(input logic [15:0] seen, input logic [15:0] expect_v);
    tests_run++;
    if (seen !== expect_v)
    begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, expect_v);
    end
  endtask : check

  task close_out;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr    <= 1'b0;
    #1;
  endtask : wr_reg

  task rd_reg(input logic [4:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1;
    check(rdata, e);
  endtask : rd_reg

  task pulse(input int k);
    @(posedge sys_clk);
    link_up <= (k == 0);
    link_dn <= (k == 1);
    wake    <= (k == 2);
    @(posedge sys_clk);
    {link_up, link_dn, wake} <= 3'h0;
    #1;
  endtask : pulse

  // the bound only guards against a stuck frame; the tail lets the last pair land
  task send(input logic [7:0] n);
    @(posedge sys_clk);
    flen  <= n;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    // busy only rises once the model has taken the start, so look after the update
    #1;
    for (int i = 0; i < 400 && busy; i++)
      @(posedge sys_clk);
    repeat (24) @(posedge sys_clk);
    #1;
  endtask : send

  // ----------------------------------------------------------------
  // transmit monitor
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (note)
      exp_q.push_back(tx_pins.txd);
    if (tx_valid === 1'b1)
      check(tx_data, exp_q.size() > 0 ? exp_q.pop_front() : 2'bXX);
  end

  initial
  begin
    #400000;
    errors++;
    close_out;
  end

  initial
  begin
    time t0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    rd_reg(ADDR_STRAP_STATUS, 16'h000F);
    check(rx_oe, 16'h0001);
    check(ref_oe, 16'h0001);
    rd_reg(ADDR_VENDOR_CTRL, 16'h0000);
    @(posedge ref_clk);
    t0 = $time;
    @(posedge ref_clk);
    check(16'($time - t0), 16'(LINK_CLK_PERIOD_NS));
    send(8'd12);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      core <= (i == 3) ? 4'h4 : 4'($random(seed));
      repeat (24) @(posedge sys_clk);
      #1;
      check(rx_out, {core.crs_dv, core.rx_er, core.crs_dv ? core.rxd : 2'h0});
    end
    @(posedge sys_clk);
    core <= 4'h0;
    rd_reg(ADDR_INT_CTRL, 16'h0004);
    wr_reg(ADDR_INT_CTRL, 16'h000F);
    pulse(0);
    rd_reg(ADDR_INT_CTRL, 16'h0001);
    check(irq, 16'h0000);
    wr_reg(ADDR_INT_CTRL, 16'h0100);
    check(irq, 16'h0001);
    check(int_wire, 16'h0000);
    wr_reg(ADDR_VENDOR_CTRL, 16'h0200);
    check(int_wire, 16'h0001);
    wr_reg(ADDR_INT_CTRL, 16'h0101);
    check(int_wire, 16'h0000);
    wr_reg(ADDR_VENDOR_CTRL, 16'h0000);
    pulse(1);
    rd_reg(ADDR_INT_CTRL, 16'h0102);
    check(irq, 16'h0000);
    wr_reg(ADDR_INT_CTRL, 16'h0002);
    wr_reg(ADDR_VENDOR_CTRL, 16'h0002);
    check(int_wire, 16'h0001);
    pulse(2);
    check(int_wire, 16'h0000);
    wr_reg(ADDR_INT_CTRL, 16'h0008);
    check(int_wire, 16'h0001);
    rd_reg(5'h05, 16'h0000);
    wr_reg(ADDR_VENDOR_CTRL, 16'h0080);
    use_xtl <= 1'b1;
    check(ref_oe, 16'h0000);
    rd_reg(ADDR_VENDOR_CTRL, 16'h0080);
    send(8'd12);
    wr_reg(ADDR_VENDOR_CTRL, 16'h0081);
    repeat (4) @(posedge sys_clk);
    #1;
    check(txd1_oe, 16'h0001);
    check(txd1, 16'h0001);
    check(16'(exp_q.size()), 16'h0000);
    // ----------------------------------------------------------------
    // second reset: clock-input variant, both straps pulled low
    // ----------------------------------------------------------------
    @(posedge sys_clk);
    variant <= 1'b1;
    strap   <= 4'h0;
    rst     <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    rd_reg(ADDR_STRAP_STATUS, 16'h0008);
    check(ref_oe, 16'h0000);
    check(txd1_oe, 16'h0000);
    rd_reg(ADDR_VENDOR_CTRL, 16'h0080);
    send(8'd4);
    check(16'(exp_q.size()), 16'h0000);
    close_out;
  end
endmodule : testbench
